// file: src/rpca_top.sv
`timescale 1ns/10ps
module rpca_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic porRst,
    input wire rpca_pkg::rpca_bus_req_t busReq,
    output logic [15:0] readData,
    output logic readValid,
    input wire logic powerDown,
    input wire logic powerdownWakeCfg,
    output logic tickRequest,
    output logic alarmRequest,
    output logic oscStop,
    output logic wakeRequest
);
    logic [15:0] ctrl_reg;
    logic [rpca_pkg::DIV_W-1:0] prescaler_reg;
    logic [rpca_pkg::DIV_W-1:0] divider_reg;
    logic [31:0] timeCount_reg;
    logic [31:0] alarmValue_reg;
    logic [15:0] readData_reg;
    logic readValid_reg;
    logic switchOff;
    logic running;
    logic stepPulse;
    logic tickEvent;
    logic matchPulse;
    logic wrEn;
    logic prescalerWrite;

    // Writes land in one cycle; the bus has no wait states.
    assign wrEn = busReq.sel && busReq.wr;
    assign switchOff = ctrl_reg[rpca_pkg::BIT_OFF];

    // Power-down and idle do not appear here: only switch-off halts the count.
    assign running = !switchOff;

    // Word address decode used by the write paths; the read path decodes in its own case.
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
        hit = (addr == off);
    endfunction

    // Protected registers take writes only while the block is switched off.
    assign prescalerWrite = wrEn && switchOff &&
        (hit(busReq.addr, {1'b0, rpca_pkg::OFF_PRE_LOW})
        || hit(busReq.addr, {1'b0, rpca_pkg::OFF_PRE_HIGH}));

    rpca_div64 u_div64 (
        .clk(clk),
        .porRst(porRst),
        .run(running),
        .stepPulse(stepPulse)
    );

    // The reference tick is the step taken while the divider stands at one or zero; it reloads instead of reaching zero.
    assign tickEvent = stepPulse && (divider_reg <= rpca_pkg::DIV_ONE);

    // Control register: flags set by events, the set wins over a software clear.
    always_ff @(posedge clk) begin
        if (srst || porRst) begin
            ctrl_reg <= rpca_pkg::CTRL_RESET;
        end else begin
            if (wrEn && hit(busReq.addr, {1'b0, rpca_pkg::OFF_CTRL})) begin
                ctrl_reg[rpca_pkg::BIT_TICK_EN] <= busReq.wdata[rpca_pkg::BIT_TICK_EN];
                ctrl_reg[rpca_pkg::BIT_ALARM_EN] <= busReq.wdata[rpca_pkg::BIT_ALARM_EN];
                ctrl_reg[rpca_pkg::BIT_OFF] <= busReq.wdata[rpca_pkg::BIT_OFF];
                ctrl_reg[rpca_pkg::BIT_TICK_FLAG] <=
                    busReq.wdata[rpca_pkg::BIT_TICK_FLAG] || tickEvent;
                ctrl_reg[rpca_pkg::BIT_ALARM_FLAG] <=
                    busReq.wdata[rpca_pkg::BIT_ALARM_FLAG] || matchPulse;
            end else begin
                if (tickEvent) begin
                    ctrl_reg[rpca_pkg::BIT_TICK_FLAG] <= 1'b1;
                end
                if (matchPulse) begin
                    ctrl_reg[rpca_pkg::BIT_ALARM_FLAG] <= 1'b1;
                end
            end
        end
    end

    // Prescaler survives system reset; only the power-on reset clears it.
    always_ff @(posedge clk) begin
        if (porRst) begin
            prescaler_reg <= '0;
        end else if (prescalerWrite) begin
            if (hit(busReq.addr, {1'b0, rpca_pkg::OFF_PRE_LOW})) begin
                prescaler_reg[15:0] <= busReq.wdata;
            end else begin
                prescaler_reg[19:16] <= busReq.wdata[rpca_pkg::DIV_HIGH_W-1:0];
            end
        end
    end

    // Divider counts down; any prescaler change is copied straight in, so the
    // next period already uses the new ratio instead of finishing the old one.
    always_ff @(posedge clk) begin
        if (porRst) begin
            divider_reg <= '0;
        end else if (prescalerWrite) begin
            if (hit(busReq.addr, {1'b0, rpca_pkg::OFF_PRE_LOW})) begin
                divider_reg <= {prescaler_reg[19:16], busReq.wdata};
            end else begin
                divider_reg <= {busReq.wdata[rpca_pkg::DIV_HIGH_W-1:0], prescaler_reg[15:0]};
            end
        end else if (tickEvent) begin
            divider_reg <= prescaler_reg;
        end else if (stepPulse) begin
            divider_reg <= divider_reg - rpca_pkg::DIV_ONE;
        end
    end

    // Time counter: direct loads while off, one step per tick while running.
    always_ff @(posedge clk) begin
        if (porRst) begin
            timeCount_reg <= '0;
        end else if (wrEn && switchOff
                && hit(busReq.addr, {1'b0, rpca_pkg::OFF_TIME_LOW})) begin
            timeCount_reg[15:0] <= busReq.wdata;
        end else if (wrEn && switchOff
                && hit(busReq.addr, {1'b0, rpca_pkg::OFF_TIME_HIGH})) begin
            timeCount_reg[31:16] <= busReq.wdata;
        end else if (tickEvent) begin
            timeCount_reg <= timeCount_reg + rpca_pkg::TIME_ONE;
        end
    end

    // Alarm halves are not protected and may be moved at any time.
    always_ff @(posedge clk) begin
        if (porRst) begin
            alarmValue_reg <= '0;
        end else if (wrEn && hit(busReq.addr, {1'b0, rpca_pkg::OFF_ALARM_LOW})) begin
            alarmValue_reg[15:0] <= busReq.wdata;
        end else if (wrEn && hit(busReq.addr, rpca_pkg::OFF_ALARM_HIGH)) begin
            alarmValue_reg[31:16] <= busReq.wdata;
        end
    end

    rpca_alarm_cmp u_alarm_cmp (
        .clk(clk),
        .porRst(porRst),
        .timeCount(timeCount_reg),
        .alarmValue(alarmValue_reg),
        .matchPulse(matchPulse)
    );

    // Read path: data one cycle after the request; unmapped words read zero.
    always_ff @(posedge clk) begin
        if (srst || porRst) begin
            readData_reg <= rpca_pkg::DATA_ZERO;
            readValid_reg <= 1'b0;
        end else begin
            readValid_reg <= busReq.sel && !busReq.wr;
            if (busReq.sel && !busReq.wr) begin
                unique case (busReq.addr)
                    {1'b0, rpca_pkg::OFF_CTRL}: readData_reg <= ctrl_reg;
                    {1'b0, rpca_pkg::OFF_PRE_LOW}: readData_reg <= prescaler_reg[15:0];
                    {1'b0, rpca_pkg::OFF_PRE_HIGH}:
                        readData_reg <= {12'h000, prescaler_reg[19:16]};
                    {1'b0, rpca_pkg::OFF_DIV_LOW}: readData_reg <= divider_reg[15:0];
                    {1'b0, rpca_pkg::OFF_DIV_HIGH}:
                        readData_reg <= {12'h000, divider_reg[19:16]};
                    {1'b0, rpca_pkg::OFF_TIME_LOW}: readData_reg <= timeCount_reg[15:0];
                    {1'b0, rpca_pkg::OFF_TIME_HIGH}:
                        readData_reg <= timeCount_reg[31:16];
                    {1'b0, rpca_pkg::OFF_ALARM_LOW}: readData_reg <= alarmValue_reg[15:0];
                    rpca_pkg::OFF_ALARM_HIGH: readData_reg <= alarmValue_reg[31:16];
                    default: readData_reg <= rpca_pkg::DATA_ZERO;
                endcase
            end
        end
    end

    assign readData = readData_reg;
    assign readValid = readValid_reg;

    // Request lines are levels so the edge-triggered interrupt inputs see a rise.
    assign tickRequest = ctrl_reg[rpca_pkg::BIT_TICK_FLAG]
        && ctrl_reg[rpca_pkg::BIT_TICK_EN];
    assign alarmRequest = ctrl_reg[rpca_pkg::BIT_ALARM_FLAG]
        && ctrl_reg[rpca_pkg::BIT_ALARM_EN];

    // Oscillator gating and wake-up are decided by the chip's power state.
    assign oscStop = switchOff && powerDown;
    assign wakeRequest = powerDown && powerdownWakeCfg
        && (tickRequest || alarmRequest);

    // All checks below run on the oscillator clock and rest while either reset is held, except reset_keep_a, which rests only during porRst.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst || porRst);

    div_reload_a: assert property (tickEvent && !prescalerWrite |=>
        divider_reg == $past(prescaler_reg))
        else $error("Divider did not reload from the prescaler at zero.");

    div_step_a: assert property (stepPulse && !tickEvent && !prescalerWrite |=>
        divider_reg == $past(divider_reg) - rpca_pkg::DIV_ONE)
        else $error("Divider did not step down by one.");

    off_freeze_a: assert property (switchOff && !prescalerWrite |=>
        $stable(divider_reg))
        else $error("Divider moved while switched off.");

    time_step_a: assert property (tickEvent && !switchOff |=>
        timeCount_reg == $past(timeCount_reg) + rpca_pkg::TIME_ONE)
        else $error("Time counter did not step on a tick.");

    pre_protect_a: assert property (wrEn && !switchOff |=>
        $stable(prescaler_reg) && $stable(timeCount_reg) || $past(tickEvent))
        else $error("Protected register changed while running.");

    tick_flag_a: assert property (tickEvent |=>
        ctrl_reg[rpca_pkg::BIT_TICK_FLAG])
        else $error("Tick event did not set its pending flag.");

    alarm_flag_a: assert property (matchPulse |=>
        ctrl_reg[rpca_pkg::BIT_ALARM_FLAG])
        else $error("Alarm match did not set its pending flag.");

    tick_gate_a: assert property (tickRequest |->
        ctrl_reg[rpca_pkg::BIT_TICK_EN] && $past(tickEvent || tickRequest
        || wrEn, 1))
        else $error("Tick request out without enable or cause.");

    osc_stop_a: assert property (oscStop |-> switchOff && powerDown)
        else $error("Oscillator stopped without switch-off in power-down.");

    wake_cfg_a: assert property (wakeRequest |-> powerdownWakeCfg && powerDown
        && (ctrl_reg[rpca_pkg::BIT_TICK_FLAG] || ctrl_reg[rpca_pkg::BIT_ALARM_FLAG]))
        else $error("Wake request raised without the wake config bit.");

    osc_run_a: assert property (!powerDown |-> !oscStop && !wakeRequest)
        else $error("Oscillator stop or wake raised outside power-down.");

    // Bus side: every read answers on the next edge and nothing else raises the valid.
    read_answer_a: assert property (busReq.sel && !busReq.wr |=> readValid)
        else $error("Read request got no valid on the next cycle.");

    read_quiet_a: assert property (!(busReq.sel && !busReq.wr) |=> !readValid)
        else $error("Read valid raised without a read request.");

    // Counting side: what may move a register, and what must leave it alone.
    step_halt_a: assert property (switchOff |-> !stepPulse)
        else $error("Pre-divider stepped while switched off.");

    div_bound_a: assert property (divider_reg <= prescaler_reg)
        else $error("Divider holds more than the prescaler value.");

    time_hold_a: assert property (!tickEvent && !(wrEn && switchOff) |=>
        $stable(timeCount_reg))
        else $error("Time counter moved without a tick or a load.");

    time_load_a: assert property (wrEn && switchOff
        && hit(busReq.addr, {1'b0, rpca_pkg::OFF_TIME_LOW}) |=>
        timeCount_reg[15:0] == $past(busReq.wdata))
        else $error("Time low half did not take the written word.");

    pre_hold_a: assert property (!prescalerWrite |=> $stable(prescaler_reg))
        else $error("Prescaler changed without an accepted write.");

    alarm_hold_a: assert property (!wrEn |=> $stable(alarmValue_reg))
        else $error("Alarm value changed without a write.");

    reset_keep_a: assert property (disable iff (porRst) srst && !wrEn |=>
        $stable(prescaler_reg) && $stable(alarmValue_reg))
        else $error("System reset disturbed the prescaler or the alarm value.");

    ctrl_write_a: assert property (wrEn
        && hit(busReq.addr, {1'b0, rpca_pkg::OFF_CTRL}) |=>
        switchOff == $past(busReq.wdata[rpca_pkg::BIT_OFF]))
        else $error("Switch-off bit did not follow the control write.");

    // Request side: pending flags hold until software writes the control word.
    tick_keep_a: assert property (ctrl_reg[rpca_pkg::BIT_TICK_FLAG] && !wrEn |=>
        ctrl_reg[rpca_pkg::BIT_TICK_FLAG])
        else $error("Tick flag dropped without a software write.");

    alarm_keep_a: assert property (ctrl_reg[rpca_pkg::BIT_ALARM_FLAG] && !wrEn |=>
        ctrl_reg[rpca_pkg::BIT_ALARM_FLAG])
        else $error("Alarm flag dropped without a software write.");

    match_once_a: assert property (matchPulse |=> !matchPulse)
        else $error("Alarm match pulsed two cycles in a row.");
endmodule // rpca_top

// file: src/rpca_pkg.sv
package rpca_pkg;
    // Register word offsets on the peripheral bus, byte addresses.
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_PRE_LOW = 4'h2;
    localparam logic [3:0] OFF_PRE_HIGH = 4'h4;
    localparam logic [3:0] OFF_DIV_LOW = 4'h6;
    localparam logic [3:0] OFF_DIV_HIGH = 4'h8;
    localparam logic [3:0] OFF_TIME_LOW = 4'hA;
    localparam logic [3:0] OFF_TIME_HIGH = 4'hC;
    localparam logic [3:0] OFF_ALARM_LOW = 4'hE;

    // Alarm high half sits past the nibble range, so the address is five bits wide.
    localparam logic [4:0] OFF_ALARM_HIGH = 5'h10;

    // Control register bit positions.
    localparam int BIT_TICK_FLAG = 0;
    localparam int BIT_TICK_EN = 1;
    localparam int BIT_ALARM_FLAG = 2;
    localparam int BIT_ALARM_EN = 3;
    localparam int BIT_OFF = 7;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Fixed front divider and field widths.
    localparam int PREDIV_W = 6;
    localparam logic [5:0] PREDIV_LAST = 6'h3F;
    localparam int DIV_W = 20;
    localparam int DIV_HIGH_W = 4;
    localparam logic [19:0] DIV_ONE = 20'h0_0001;
    localparam logic [31:0] TIME_ONE = 32'h0000_0001;
    localparam logic [15:0] DATA_ZERO = 16'h0000;

    // One bus request from the processor.
    typedef struct packed {
        logic sel;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } rpca_bus_req_t;
endpackage

// file: src/rpca_div64.sv
`timescale 1ns/10ps
// Fixed divide-by-64 front stage; emits one enable pulse per 64 running cycles.
module rpca_div64 (
    input wire logic clk,
    input wire logic porRst,
    input wire logic run,
    output logic stepPulse
);
    logic [rpca_pkg::PREDIV_W-1:0] preCount_reg;

    // The count freezes while stopped, so a restart resumes the same phase.
    always_ff @(posedge clk) begin
        if (porRst) begin
            preCount_reg <= '0;
        end else if (run) begin
            preCount_reg <= preCount_reg + 1'b1;
        end
    end

    assign stepPulse = run && (preCount_reg == rpca_pkg::PREDIV_LAST);
endmodule // rpca_div64

// file: src/rpca_alarm_cmp.sv
`timescale 1ns/10ps
// Compares the time counter with the alarm value and pulses once per new match.
module rpca_alarm_cmp (
    input wire logic clk,
    input wire logic porRst,
    input wire logic [31:0] timeCount,
    input wire logic [31:0] alarmValue,
    output logic matchPulse
);
    logic equal_reg;
    logic equalNow;

    // Edge detection keeps a stopped counter from re-raising the alarm forever.
    assign equalNow = (timeCount == alarmValue);

    always_ff @(posedge clk) begin
        if (porRst) begin
            equal_reg <= 1'b1; // Both sides clear to zero, so no false match follows reset.
        end else begin
            equal_reg <= equalNow;
        end
    end

    assign matchPulse = equalNow && !equal_reg;
endmodule // rpca_alarm_cmp

// file: testbench/rpca_cpu_model.sv
`timescale 1ns/10ps
// Processor side of the peripheral bus; one access at a time, strobe held for one cycle.
module rpca_cpu_model (
    input wire logic clk,
    output rpca_pkg::rpca_bus_req_t busReq,
    input wire logic [15:0] readData,
    input wire logic readValid
);
    // The bus starts idle so nothing is requested while reset is held.
    initial begin
        busReq = '0;
    end

    // Requests change just after an edge and are dropped after the taking edge.
    task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] wdata,
        output logic [15:0] rdata, output logic rdValid);
        @(posedge clk);
        #1;
        busReq = '{sel: 1'b1, wr: wr, addr: addr, wdata: wdata};
        @(posedge clk);
        #1;
        // Released lines carry the inverse of the last value, so stale data never looks right.
        busReq = '{sel: 1'b0, wr: ~wr, addr: ~addr, wdata: ~wdata};
        rdValid = readValid;
        rdata = readData;
    endtask
endmodule // rpca_cpu_model

// file: testbench/tb_rtc_prescaler_counter_alarm.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin errCount++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
// Drives the clock block as the processor would and checks it against a small model.
module tb_rtc_prescaler_counter_alarm;
    localparam int PRE = 3;
    localparam logic [4:0] A_CTRL = {1'b0, rpca_pkg::OFF_CTRL};
    localparam logic [4:0] A_PRE_LOW = {1'b0, rpca_pkg::OFF_PRE_LOW};
    localparam logic [4:0] A_PRE_HIGH = {1'b0, rpca_pkg::OFF_PRE_HIGH};
    localparam logic [4:0] A_DIV_LOW = {1'b0, rpca_pkg::OFF_DIV_LOW};
    localparam logic [4:0] A_DIV_HIGH = {1'b0, rpca_pkg::OFF_DIV_HIGH};
    localparam logic [4:0] A_TIME_LOW = {1'b0, rpca_pkg::OFF_TIME_LOW};
    localparam logic [4:0] A_TIME_HIGH = {1'b0, rpca_pkg::OFF_TIME_HIGH};
    localparam logic [4:0] A_ALARM_LOW = {1'b0, rpca_pkg::OFF_ALARM_LOW};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic porRst = 1'b1;
    logic powerDown = 1'b0;
    logic powerdownWakeCfg = 1'b0;
    logic [15:0] readData;
    logic readValid, tickRequest, alarmRequest, oscStop, wakeRequest;
    rpca_pkg::rpca_bus_req_t busReq;
    int errCount = 0;
    int nCompared = 0;
    logic [31:0] timeExp, alarmVal;
    time t1, t2;

    // A 50 ns period gives the 20 MHz oscillator clock.
    always #25 clk = ~clk;

    rpca_top rpca_top_i (.clk(clk), .srst(srst), .porRst(porRst), .busReq(busReq),
        .readData(readData), .readValid(readValid), .powerDown(powerDown),
        .powerdownWakeCfg(powerdownWakeCfg), .tickRequest(tickRequest),
        .alarmRequest(alarmRequest), .oscStop(oscStop), .wakeRequest(wakeRequest));
    rpca_cpu_model rpca_cpu_model_i (.clk(clk), .busReq(busReq), .readData(readData),
        .readValid(readValid));

    // Bus helpers; a read also checks that the answer arrives one cycle later.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] r;
        logic v;
        rpca_cpu_model_i.access(1'b1, a, d, r, v);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        rpca_cpu_model_i.access(1'b0, a, 16'h0000, d, v);
        `CHK(v, 1'b1)
        `CHK(d, exp)
    endtask
    // Waits a bounded number of cycles for a request and records when it showed.
    task automatic wait_req(input logic alarm, input int limit, output time at);
        int n;
        n = 0;
        while ((alarm ? alarmRequest : tickRequest) !== 1'b1 && n < limit) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(n < limit, 1'b1)
        at = $time;
    endtask
    task automatic give_verdict();
        if (errCount == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // The whole run needs under a thousand cycles; this is well beyond that.
    initial begin
        #1_000_000;
        errCount++;
        give_verdict();
    end

    // Power-on reset drops first; the system reset is held two cycles longer.
    initial begin
        void'($urandom(41));
        repeat (10) @(posedge clk);
        #1 porRst = 1'b0;
        repeat (2) @(posedge clk);
        #1 srst = 1'b0;
        rd(A_CTRL, 16'h0000);
        rd(5'h12, 16'h0000);
        wr(A_PRE_LOW, 16'(PRE));
        rd(A_PRE_LOW, 16'h0000);
        // Stopped block accepts prescaler and time; divider follows the prescaler.
        wr(A_CTRL, 16'h0080);
        wr(A_PRE_HIGH, 16'hFFF5);
        rd(A_PRE_HIGH, 16'h0005);
        rd(A_DIV_HIGH, 16'h0005);
        wr(A_PRE_HIGH, 16'h0000);
        wr(A_PRE_LOW, 16'(PRE));
        wr(A_DIV_LOW, 16'h1234);
        rd(A_DIV_LOW, 16'(PRE));
        rd(A_DIV_HIGH, 16'h0000);
        timeExp = $urandom() | 32'h0000_0100;
        alarmVal = timeExp + 32'h0000_0002;
        wr(A_TIME_LOW, timeExp[15:0]);
        wr(A_TIME_HIGH, timeExp[31:16]);
        wr(A_ALARM_LOW, alarmVal[15:0]);
        wr(rpca_pkg::OFF_ALARM_HIGH, alarmVal[31:16]);
        repeat (200) @(posedge clk);
        rd(A_TIME_LOW, timeExp[15:0]);
        rd(A_TIME_HIGH, timeExp[31:16]);
        // Running: the first tick comes at an unknown pre-divider phase.
        wr(A_CTRL, 16'h000A);
        wait_req(1'b0, 64 * PRE + 80, t1);
        timeExp = timeExp + 32'h0000_0001;
        rd(A_TIME_LOW, timeExp[15:0]);
        rd(A_TIME_HIGH, timeExp[31:16]);
        wr(A_CTRL, 16'h000A);
        `CHK(tickRequest, 1'b0)
        wait_req(1'b0, 64 * PRE + 8, t2);
        `CHK(t2 - t1, time'(64 * PRE * 50))
        timeExp = timeExp + 32'h0000_0001;
        wait_req(1'b1, 4, t1);
        rd(A_CTRL, 16'h000F);
        // Pending flags only reach the outputs while enabled.
        wr(A_CTRL, 16'h0005);
        `CHK({tickRequest, alarmRequest}, 2'b00)
        wr(A_CTRL, 16'h000F);
        `CHK({tickRequest, alarmRequest}, 2'b11)
        powerDown = 1'b1;
        @(posedge clk);
        #1;
        `CHK({oscStop, wakeRequest}, 2'b00)
        powerdownWakeCfg = 1'b1;
        @(posedge clk);
        #1;
        `CHK(wakeRequest, 1'b1)
        repeat (64 * PRE) @(posedge clk);
        timeExp = timeExp + 32'h0000_0001;
        rd(A_TIME_LOW, timeExp[15:0]);
        wr(A_CTRL, 16'h0080);
        `CHK({oscStop, wakeRequest}, 2'b10)
        powerDown = 1'b0;
        powerdownWakeCfg = 1'b0;
        @(posedge clk);
        #1;
        `CHK(oscStop, 1'b0)
        // A system reset clears control only; counts and settings survive.
        srst = 1'b1;
        repeat (2) @(posedge clk);
        #1 srst = 1'b0;
        rd(A_CTRL, 16'h0000);
        rd(A_TIME_LOW, timeExp[15:0]);
        rd(A_TIME_HIGH, timeExp[31:16]);
        rd(A_PRE_LOW, 16'(PRE));
        rd(A_ALARM_LOW, alarmVal[15:0]);
        rd(rpca_pkg::OFF_ALARM_HIGH, alarmVal[31:16]);
        rd(A_PRE_HIGH, 16'h0000);
        give_verdict();
    end
endmodule // tb_rtc_prescaler_counter_alarm
